// [sleep_ctl_pkg.sv]
`default_nettype none
package sleep_ctl_pkg;
    // clock and timing
    localparam int CLK_HZ        = 25_000_000;
    localparam int TICK_MS       = 10;
    localparam int TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
    localparam int POLL_MS       = 100;
    localparam int POLL_TICKS    = POLL_MS / TICK_MS;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_OPT    = 8'h04;
    localparam logic [7:0] OFS_PERIOD = 8'h08;
    localparam logic [7:0] OFS_COUNT  = 8'h0C;
    localparam logic [7:0] OFS_AWAKE  = 8'h10;
    localparam logic [7:0] OFS_CMD    = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_FLOW_BIT  = 3;
    localparam int OPT_FULL_BIT   = 1;
    localparam int OPT_EXT_BIT    = 2;
    localparam int CMD_SLEEP_BIT  = 0;
    localparam int STAT_IND_BIT   = 2;
    localparam int STAT_LP_BIT    = 3;
    localparam int STAT_CTS_BIT   = 4;
    localparam int STAT_JOIN_BIT  = 5;
    localparam int STAT_WAKES_LSB = 16;

    // sleep mode encodings
    localparam logic [2:0] MODE_PIN     = 3'h1;
    localparam logic [2:0] MODE_CYC     = 3'h4;
    localparam logic [2:0] MODE_CYC_PIN = 3'h5;

    // ranges and reset values
    localparam logic [11:0] SP_MIN    = 12'h020;
    localparam logic [11:0] SP_MAX    = 12'hAF0;
    localparam logic [15:0] SN_MIN    = 16'h0001;
    localparam logic [2:0]  MODE_RST  = 3'h0;
    localparam logic [7:0]  OPT_RST   = 8'h00;
    localparam logic [11:0] SP_RST    = 12'h020;
    localparam logic [15:0] SN_RST    = 16'h0001;
    localparam logic [15:0] ST_RST    = 16'h01F4;

    typedef enum logic [1:0] {
        ST_SLEEP = 2'b00,
        ST_POLL  = 2'b01,
        ST_AWAKE = 2'b11,
        ST_DRAIN = 2'b10
    } pstate_t;
endpackage
`default_nettype wire

// [end_device_sleep_controller.sv]
// Our own choices: the register addresses and the APB interface to the registers.
`default_nettype none
// Functional notes
// - sleep mode setting 1 selects sleep and wake by request pin level.
// - pin sleep waits for transmit or receive in progress to finish.
// - unjoined device defers pin sleep until the join scan completes.
// - pin mode wakes when the request pin goes low.
// - awake and joined in pin mode, poll parent every 100 ms.
// - settings 4 or 5 select timed cyclic sleep with brief poll wakes.
// - setting 5 also wakes on request pin falling edge; 4 does not.
// - after cyclic poll stay awake on pending data or serial data, else sleep.
// - cyclic mode raises awake indicator on wake, drops it on sleep.
// - with flow control, CTS low when awake and accepting, high when sleeping.
// - awake timer starts on serial or radio data and restarts on each arrival.
// - timer running polls every 100 ms; sleeps on expiry or sleep command.
// - sleep period setting 0x20 to 0xAF0 in 10 ms units.
// - period count 1 to 0xFFFF multiplies sleep periods.
// - option 0x02 forces full awake time, 0x04 enables extended sleep.
// - options 0x00 or 0x02 give short sleep of one period then poll.
// - short sleep with parent data starts timer and polls every 100 ms.
// - count 1 raises indicator each wake; above 1 on radio data or count wakes.
// - silent polling raises indicator at once when radio data arrives.
// - extended sleep lasts period times count, period in 10 ms units.
// - transmit only when awake and joined, directly to parent.
// - asleep device ignores serial and radio data.
module end_device_sleep_controller
    import sleep_ctl_pkg::*;
#(
    parameter int TICK_CYCLES = sleep_ctl_pkg::TICK_CYC  // clocks per 10 ms tick
) (
    input  wire logic        pclk,              // apb clock, 25 MHz
    input  wire logic        presetn,           // async reset, active low
    // register bus
    input  wire logic [7:0]  paddr,             // apb byte address
    input  wire logic        psel,              // apb select
    input  wire logic        penable,           // apb access phase
    input  wire logic        pwrite,            // apb direction
    input  wire logic [31:0] pwdata,            // apb write data
    output logic      [31:0] prdata,            // apb read data
    output logic             pready,            // apb ready
    output logic             pslverr,           // apb error
    // host pins and radio status
    input  wire logic        sleep_request_pin, // host sleep request, async
    input  wire logic        serial_rx_evt,     // serial byte arrived, pulse
    input  wire logic        radio_rx_evt,      // radio data arrived, pulse
    input  wire logic        joined,            // joined to a network
    input  wire logic        join_busy,         // join attempt or scan running
    input  wire logic        txrx_busy,         // transfer or ack wait running
    input  wire logic        poll_ack,          // parent ack to poll, pulse
    input  wire logic        poll_ack_pending,  // ack says data pending
    // radio requests and host indicators
    output logic             poll_req,          // send poll to parent, pulse
    output logic             awake_ind,         // awake indicator
    output logic             cts_n,             // serial flow control, low = send
    output logic             low_power,         // radio in low power state
    output logic             data_accept,       // serial and radio data taken
    output logic             tx_allowed         // transmit to parent allowed
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
    localparam logic [3:0]    POLL_LAST = 4'(POLL_TICKS - 1);

    typedef struct packed {
        // configuration
        logic [2:0]  mode;
        logic        flow;
        logic [7:0]  opt;
        logic [11:0] sp;
        logic [15:0] sn;
        logic [15:0] st;
        // sequencing
        pstate_t     ps;
        // synchroniser
        logic        rq_m;
        logic        rq_s;
        logic        rq_p;
        // timers
        logic [TW-1:0] tick;
        logic [3:0]  poll;
        logic [27:0] slp;
        logic [15:0] awk;
        logic [15:0] wakes;
        logic        ind;
        logic        preq;
        // bus
        logic [31:0] rdata;
        logic        err;
    } regs_t;

    regs_t q;
    regs_t n;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic is_cyc(input logic [2:0] m);
        return (m == MODE_CYC) || (m == MODE_CYC_PIN);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        unique case (a)
            OFS_CTRL, OFS_OPT, OFS_PERIOD, OFS_COUNT: hit = 1'b1;
            OFS_AWAKE, OFS_CMD, OFS_STATUS:           hit = 1'b1;
            default:                                  hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic period_bad(input logic [31:0] d);
        return (d[11:0] < SP_MIN) || (d[11:0] > SP_MAX) || (d[31:12] != '0);
    endfunction

    function automatic logic count_bad(input logic [31:0] d);
        return (d[15:0] < SN_MIN) || (d[31:16] != '0);
    endfunction

    // non-cyclic modes or count 1 light the indicator on every wake, otherwise every sn-th one
    function automatic logic ind_due(input logic c, input logic [15:0] sn, input logic [15:0] w);
        return !c || (sn == SN_MIN) || (w >= sn);
    endfunction

    function automatic logic [31:0] pack_status(input pstate_t s, input logic i, input logic c,
                                                input logic j, input logic [15:0] w);
        logic [31:0] v;
        v                     = '0;
        v[1:0]                = s;
        v[STAT_IND_BIT]       = i;
        v[STAT_LP_BIT]        = (s == ST_SLEEP);
        v[STAT_CTS_BIT]       = c;
        v[STAT_JOIN_BIT]      = j;
        v[STAT_WAKES_LSB+:16] = w;
        return v;
    endfunction

    function automatic logic [31:0] read_word(input logic [7:0] a, input regs_t r, input logic [31:0] s);
        logic [31:0] v;
        v = '0;
        unique case (a)
            OFS_CTRL:   v = {28'h0, r.flow, r.mode};
            OFS_OPT:    v = {24'h0, r.opt};
            OFS_PERIOD: v = {20'h0, r.sp};
            OFS_COUNT:  v = {16'h0, r.sn};
            OFS_AWAKE:  v = {16'h0, r.st};
            OFS_STATUS: v = s;
            default:    v = '0;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state
    logic        setup;
    logic        wr;
    logic        tk;
    logic        fall;
    logic        awake;
    logic        data_evt;
    logic        rf_evt;
    logic        si;
    logic        cyc;
    logic        wake;
    logic        poll_due;
    logic        bad_wr;

    logic        period_done;
    logic        pin_wake;
    logic        awk_done;
    logic        poll_stay;
    logic        poll_leave;

    logic [27:0] dur;
    logic [27:0] slp_nx;
    logic [15:0] wakes_nx;
    logic [31:0] status;

    always_comb begin
        n        = q;
        n.preq   = 1'b0;
        setup    = psel && !penable;
        wr       = psel && penable && pwrite && !q.err;
        tk       = (q.tick == TICK_LAST);
        n.tick   = tk ? '0 : q.tick + TW'(1);

        ////////////////////////////////////////////////////////////////////////
        // request pin synchroniser and event gating
        // first stage feeds only the second
        n.rq_m   = sleep_request_pin;
        n.rq_s   = q.rq_m;
        n.rq_p   = q.rq_s;
        fall     = q.rq_p && !q.rq_s;
        awake    = (q.ps == ST_POLL) || (q.ps == ST_AWAKE);
        data_evt = awake && (serial_rx_evt || radio_rx_evt);
        rf_evt   = awake && radio_rx_evt;
        si       = wr && (paddr == OFS_CMD) && pwdata[CMD_SLEEP_BIT];
        cyc      = is_cyc(q.mode);
        if (q.opt[OPT_EXT_BIT]) begin
            dur = 28'(q.sp) * 28'(q.sn);
        end else begin
            dur = 28'(q.sp);
        end
        slp_nx   = q.slp + 28'h1;
        wakes_nx = q.wakes + 16'h1;
        wake     = 1'b0;
        status   = pack_status(q.ps, q.ind, cts_n, joined, q.wakes);

        ////////////////////////////////////////////////////////////////////////
        // apb: read data and error latched in setup, write in access
        bad_wr = pwrite && (((paddr == OFS_PERIOD) && period_bad(pwdata)) ||
                            ((paddr == OFS_COUNT) && count_bad(pwdata)));
        if (setup) begin
            n.err   = !mapped(paddr) || bad_wr;
            // read data latched a cycle early, so the access needs no wait state
            n.rdata = read_word(paddr, q, status);
        end
        // writes land only at the access edge
        if (wr) begin
            unique case (paddr)
                OFS_CTRL: begin
                    n.mode = pwdata[CTRL_MODE_LSB+:3];
                    n.flow = pwdata[CTRL_FLOW_BIT];
                end
                OFS_OPT:    n.opt = pwdata[7:0];
                OFS_PERIOD: n.sp  = pwdata[11:0];
                OFS_COUNT:  n.sn  = pwdata[15:0];
                OFS_AWAKE:  n.st  = pwdata[15:0];
                default: ;
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // 100 ms poll cadence while awake
        poll_due = 1'b0;
        if (awake && tk) begin
            n.poll   = q.poll + 4'h1;
            if (q.poll == POLL_LAST) begin
                n.poll   = '0;
                poll_due = 1'b1;
            end
        end

        period_done = tk && (slp_nx >= dur);
        pin_wake    = (q.mode == MODE_CYC_PIN) && fall;
        awk_done    = tk && (q.awk + 16'h1 >= q.st);
        poll_stay   = data_evt || (poll_ack && poll_ack_pending) || q.opt[OPT_FULL_BIT];
        poll_leave  = (poll_ack && !poll_ack_pending) || (!joined && !join_busy) || poll_due;

        ////////////////////////////////////////////////////////////////////////
        // sequencer
        unique case (q.ps)
            // asleep: rx ignored, period ticks counted in cyclic modes
            ST_SLEEP: begin
                if (q.mode == MODE_PIN) begin
                    wake = !q.rq_s;
                end else if (cyc) begin
                    if (tk) begin
                        n.slp = slp_nx;
                    end
                    // pin wake only honoured in setting 5
                    wake = period_done || pin_wake;
                end else begin
                    wake = 1'b1;
                end
                if (wake) begin
                    n.ps    = ST_POLL;
                    n.poll  = '0;
                    // restart the tick so the first poll gap is a full 100 ms
                    n.tick  = '0;
                    n.slp   = '0;
                    n.preq  = joined;
                    n.wakes = wakes_nx;
                    if (ind_due(cyc, q.sn, wakes_nx)) begin
                        n.ind   = 1'b1;
                        n.wakes = '0;
                    end
                end
            end

            // first poll after a wake
            ST_POLL: begin
                if (!cyc) begin
                    n.ps = (q.mode == MODE_PIN && q.rq_s) ? ST_DRAIN : ST_AWAKE;
                end else if (poll_stay) begin
                    n.ps  = ST_AWAKE;
                    n.awk = '0;
                end else if (poll_leave) begin
                    // no data: straight back to sleep, timeout covers a lost ack
                    n.ps = ST_DRAIN;
                end
                if (rf_evt) begin
                    n.ind   = 1'b1;
                    n.wakes = '0;
                end
            end

            // awake, polling every 100 ms; awake timer runs in cyclic modes only, pin mode waits for the request pin
            ST_AWAKE: begin
                if (poll_due && joined) begin
                    n.preq = 1'b1;
                end
                if (q.mode == MODE_PIN) begin
                    if (q.rq_s) begin
                        n.ps = ST_DRAIN;
                    end
                end else if (cyc) begin
                    if (tk) begin
                        n.awk = q.awk + 16'h1;
                    end
                    if (data_evt) begin
                        n.awk = '0;
                    end else if (si || awk_done) begin
                        n.ps = ST_DRAIN;
                    end
                    if (rf_evt) begin
                        n.ind   = 1'b1;
                        n.wakes = '0;
                    end
                end
            end

            // radio and join work must finish before sleeping
            ST_DRAIN: begin
                if (q.mode == MODE_PIN && !q.rq_s) begin
                    n.ps = ST_AWAKE;
                end else if (!txrx_busy && !join_busy) begin
                    n.ps  = ST_SLEEP;
                    n.ind = 1'b0;
                    n.slp = '0;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.mode  <= MODE_RST;
            q.flow  <= 1'b0;
            q.opt   <= OPT_RST;
            q.sp    <= SP_RST;
            q.sn    <= SN_RST;
            q.st    <= ST_RST;
            q.ps    <= ST_POLL;
            q.rq_m  <= 1'b0;
            q.rq_s  <= 1'b0;
            q.rq_p  <= 1'b0;
            q.tick  <= '0;
            q.poll  <= 4'h0;
            q.slp   <= 28'h0;
            q.awk   <= 16'h0;
            q.wakes <= 16'h0;
            q.ind   <= 1'b1;
            q.preq  <= 1'b0;
            q.rdata <= 32'h0;
            q.err   <= 1'b0;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata      = q.rdata;
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && q.err;

    // host and radio side
    assign poll_req    = q.preq;
    assign awake_ind   = q.ind;
    assign low_power   = (q.ps == ST_SLEEP);
    // drain counts as going to sleep, so serial input is refused there
    assign data_accept = (q.ps == ST_POLL) || (q.ps == ST_AWAKE);
    assign cts_n       = q.flow && !data_accept;
    assign tx_allowed  = data_accept && joined;

endmodule // end_device_sleep_controller
`default_nettype wire

// [sleep_ctl_sva.sv]
`default_nettype none
module sleep_ctl_sva #(
    parameter int TICK_CYCLES = 4 // clocks per tick
) (
    input wire logic pclk,        // clock
    input wire logic presetn,     // reset, active low
    input wire logic psel,        // apb select
    input wire logic penable,     // apb access
    input wire logic pready,      // apb ready
    input wire logic pslverr,     // apb error
    input wire logic joined,      // joined flag
    input wire logic join_busy,   // join running
    input wire logic txrx_busy,   // transfer running
    input wire logic poll_req,    // poll pulse
    input wire logic awake_ind,   // awake indicator
    input wire logic cts_n,       // flow control
    input wire logic low_power,   // asleep
    input wire logic data_accept, // data taken
    input wire logic tx_allowed   // transmit gate
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    asleep_mute_a: assert property (low_power |-> !data_accept && !poll_req) else $error("asleep yet active");
    tx_gate_a: assert property (tx_allowed == (data_accept && joined)) else $error("transmit gate wrong");
    poll_pulse_a: assert property (poll_req |=> !poll_req) else $error("poll pulse too long");
    cts_block_a: assert property (cts_n |-> !data_accept) else $error("cts off while accepting");
    sleep_entry_a: assert property ($rose(low_power) |-> !$past(txrx_busy) && !$past(join_busy))
        else $error("slept during busy");
    ind_drop_a: assert property ($fell(awake_ind) |-> low_power) else $error("indicator fell awake");
    ind_asleep_a: assert property (low_power && $past(low_power) |-> !awake_ind) else $error("indicator on asleep");
    wake_poll_a: assert property ($fell(low_power) && joined |-> ##[0:2] poll_req) else $error("no poll on wake");
    err_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
    ready_now_a: assert property (psel && penable |-> pready) else $error("ready missing");
    cover property ($rose(low_power));
    cover property ($fell(low_power) ##[1:3] poll_req);
    cover property (pslverr);
endmodule // sleep_ctl_sva
bind end_device_sleep_controller sleep_ctl_sva #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .joined(joined), .join_busy(join_busy),
    .txrx_busy(txrx_busy), .poll_req(poll_req), .awake_ind(awake_ind), .cts_n(cts_n), .low_power(low_power),
    .data_accept(data_accept), .tx_allowed(tx_allowed));
`default_nettype wire

// [parent_model.sv]
`default_nettype none
module parent_model (
    input  wire logic       pclk,            // clock
    input  wire logic       presetn,         // reset, active low
    input  wire logic       poll_req,        // poll from device
    input  wire logic       pend,            // parent holds data
    input  wire logic [2:0] lag,             // answer delay, 1 is prompt
    output logic            poll_ack,        // ack pulse
    output logic            poll_ack_pending // data flag with ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] wait_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 3'h0;
            poll_ack <= 1'b0;
            poll_ack_pending <= 1'b0;
        end else begin
            poll_ack <= 1'b0;
            // flag toggles outside the ack so a stale value is never trusted
            poll_ack_pending <= ~poll_ack_pending;
            if (poll_req) wait_q <= lag;
            else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
            if (wait_q == 3'h1) begin
                poll_ack <= 1'b1;
                poll_ack_pending <= pend;
            end
        end
    end
endmodule // parent_model
`default_nettype wire

// [tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sleep_ctl_pkg::*;
    localparam int T = 4; // short tick keeps runs brief
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        pin, srx, rrx, joined, jbusy, tbusy, pend, ack, ackp, preq, ind, cts_n, lp, acc, txa;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] rnd;
    logic [2:0]  lag;
    int          n_mismatch, tests_run, n, sp;
    logic [39:0] rv[6] = '{40'h00_00000000, 40'h04_00000000, 40'h08_00000020, 40'h0C_00000001,
                           40'h10_000001F4, 40'h14_00000000};
    logic [40:0] bad[5] = '{41'h1_08_0000001F, 41'h1_08_00000AF1, 41'h0_08_00000AF0, 41'h1_0C_00000000,
                            41'h1_1C_00000001};
    end_device_sleep_controller #(.TICK_CYCLES(T)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_request_pin(pin), .serial_rx_evt(srx), .radio_rx_evt(rrx), .joined(joined),
        .join_busy(jbusy), .txrx_busy(tbusy), .poll_ack(ack), .poll_ack_pending(ackp), .poll_req(preq),
        .awake_ind(ind), .cts_n(cts_n), .low_power(lp), .data_accept(acc), .tx_allowed(txa));
    parent_model par_u (.pclk(pclk), .presetn(presetn), .poll_req(preq), .pend(pend), .lag(lag),
        .poll_ack(ack), .poll_ack_pending(ackp));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int nap(input int p, input int c, input logic ext);
        return p * T * (ext ? c : 1);
    endfunction
    task automatic wrap_up;
        if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rng(input int g, input int lo, input int hi);
        chk(32'((g >= lo && g <= hi) ? lo : g), 32'(lo));
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wlp(input logic v, output int c);
        c = 0;
        while (lp !== v && c < 9000) begin
            @(posedge pclk);
            c++;
        end
    endtask
    task automatic wpoll(output int c);
        c = 0;
        while (preq !== 1'b1 && c < 500) begin
            @(posedge pclk);
            c++;
        end
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (preq !== 1'b1 && c < 500);
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        {psel, penable, pwrite, pin, srx, rrx, jbusy, tbusy, pend, presetn} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        joined = 1'b1;
        lag = 3'h2;
        rnd = 16'h3B76; // seed 15222
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rv[i]) begin
            apb(rv[i][39:32], 1'b0, 32'h0);
            chk(rd, rv[i][31:0]);
        end
        foreach (bad[i]) begin
            apb(bad[i][39:32], 1'b1, bad[i][31:0]);
            chk(er, bad[i][40]);
        end
        apb(OFS_PERIOD, 1'b0, 32'h0);
        chk(rd, 32'h0AF0);
        apb(8'h1C, 1'b0, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        ///////////////////////////////////////////////////////////////
        apb(OFS_CTRL, 1'b1, 32'h9);
        tbusy <= 1'b1;
        pin <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(lp, 1'b0);
        tbusy <= 1'b0;
        wlp(1'b1, n);
        rng(n, 0, 4);
        chk(cts_n, 1'b1);
        chk(txa, 1'b0);
        pin <= 1'b0;
        wlp(1'b0, n);
        rng(n, 2, 6);
        chk(txa, 1'b1);
        wpoll(n);
        chk(n, 10 * T);
        joined <= 1'b0;
        jbusy <= 1'b1;
        pin <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(lp, 1'b0);
        jbusy <= 1'b0;
        wlp(1'b1, n);
        rng(n, 0, 4);
        pin <= 1'b0;
        joined <= 1'b1;
        ///////////////////////////////////////////////////////////////
        rnd = lfsr(rnd);
        sp = 32 + int'(rnd[3:0]);
        apb(OFS_PERIOD, 1'b1, 32'(sp));
        apb(OFS_AWAKE, 1'b1, 32'd25);
        apb(OFS_CTRL, 1'b1, 32'hC);
        apb(OFS_CMD, 1'b1, 32'h1);
        wlp(1'b1, n);
        wlp(1'b0, n);
        rng(n, nap(sp, 1, 1'b0) - T, nap(sp, 1, 1'b0) + T);
        repeat (2) @(posedge pclk);
        chk({ind, cts_n}, 32'h2);
        wlp(1'b1, n);
        rng(n, 0, 20);
        pend <= 1'b1;
        lag <= 3'h5;
        wlp(1'b0, n);
        wpoll(n);
        chk(n, 10 * T);
        apb(OFS_CMD, 1'b1, 32'h1);
        wlp(1'b1, n);
        rng(n, 0, 6);
        pend <= 1'b0;
        apb(OFS_COUNT, 1'b1, 32'h3);
        wlp(1'b0, n);
        repeat (2) @(posedge pclk);
        chk(ind, 1'b0);
        wlp(1'b1, n);
        wlp(1'b0, n);
        rrx <= 1'b1;
        @(posedge pclk);
        rrx <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(ind, 1'b1);
        apb(OFS_COUNT, 1'b1, 32'h2);
        apb(OFS_OPT, 1'b1, 32'h6);
        wlp(1'b1, n);
        wlp(1'b0, n);
        wlp(1'b1, n);
        wlp(1'b0, n);
        rng(n, nap(sp, 2, 1'b1) - T, nap(sp, 2, 1'b1) + T);
        ///////////////////////////////////////////////////////////////
        wlp(1'b1, n);
        pin <= 1'b1;
        repeat (4) @(posedge pclk);
        pin <= 1'b0;
        srx <= 1'b1;
        @(posedge pclk);
        srx <= 1'b0;
        repeat (7) @(posedge pclk);
        chk({lp, acc}, 32'h2);
        apb(OFS_CTRL, 1'b1, 32'hD);
        pin <= 1'b1;
        repeat (4) @(posedge pclk);
        pin <= 1'b0;
        wlp(1'b0, n);
        rng(n, 2, 8);
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
